// file: scss_pkg.sv
// Package with constants for the subordinate cycle sync shift block.
package scss_pkg;
	localparam logic [7:0]  SCSS_OUT_SYNC_TYPE      = 8'h03;
	localparam logic [7:0]  SCSS_IN_SYNC_TYPE       = 8'h01;
	localparam logic [1:0]  SCSS_DC_SUBORDINATE     = 2'h2;
	localparam logic [1:0]  SCSS_SHIFT_NONE         = 2'h0;
	localparam logic [1:0]  SCSS_SHIFT_LOCAL_TIMER  = 2'h1;
	localparam int          SCSS_SUP_DC_LSB         = 2;
	localparam int          SCSS_SUP_SHIFT_LSB      = 4;
	localparam logic [31:0] SCSS_CYCLE_RST          = 32'h0000_0000;
	localparam logic [15:0] SCSS_COUNT_RST          = 16'h0000;
	localparam int          SCSS_CLK_PERIOD_NS      = 10;
	localparam int          SCSS_TICK_NS            = 10;
	localparam int          SCSS_TICK_CYCLES        = (SCSS_TICK_NS + SCSS_CLK_PERIOD_NS - 1) / SCSS_CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SCSS_IDLE  = 2'b00,
		SCSS_COUNT = 2'b01,
		SCSS_FIRE  = 2'b10
	} scss_state_e;
endpackage

// file: scss_shift_timer.sv
// Shift timer that fires a strobe a programmed number of ticks after a trigger.
`timescale 1ns/1ns
`default_nettype none
module scss_shift_timer
	import scss_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic         i_tick,
	input  wire logic         i_trig,
	input  wire logic         i_enable,
	input  wire logic [W-1:0] i_shift,
	output logic              o_strobe,
	output logic              o_busy
);
	scss_state_e  state_r;
	logic [W-1:0] cnt_r;

	// A new trigger restarts the delay; a pending strobe is dropped unless the trigger comes in the SCSS_FIRE cycle.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= SCSS_IDLE;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				SCSS_IDLE: begin
					if (i_trig) begin
						cnt_r   <= i_shift;
						state_r <= (!i_enable || i_shift == '0) ? SCSS_FIRE : SCSS_COUNT;
					end
				end
				SCSS_COUNT: begin
					if (i_trig) begin
						cnt_r   <= i_shift;
						state_r <= (!i_enable || i_shift == '0) ? SCSS_FIRE : SCSS_COUNT;
					end else if (i_tick) begin
						cnt_r <= cnt_r - 1'b1;
						if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
							state_r <= SCSS_FIRE;
						end
					end
				end
				SCSS_FIRE: begin
					if (i_trig) begin
						cnt_r   <= i_shift;
						state_r <= (!i_enable || i_shift == '0) ? SCSS_FIRE : SCSS_COUNT;
					end else begin
						state_r <= SCSS_IDLE;
					end
				end
				default: state_r <= SCSS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_strobe <= 1'b0;
		end else begin
			o_strobe <= (state_r == SCSS_FIRE);
		end
	end

	assign o_busy = (state_r == SCSS_COUNT);
endmodule // scss_shift_timer
`default_nettype wire

// file: scss_top.sv
// Subordinate-cycle synchronisation: local cycle start, shifted strobes and sync entries.
`timescale 1ns/1ns
`default_nettype none
module scss_top
	import scss_pkg::*;
#(
	parameter int TW = 32,
	parameter int CW = 16
) (
	input  wire logic          i_clk,
	input  wire logic          i_srst,
	input  wire logic          i_sync0,
	input  wire logic          i_sync1,
	input  wire logic          i_buf_event,
	input  wire logic          i_toggle_fault,
	input  wire logic          i_cycle_too_small,
	input  wire logic          i_out_shift_en,
	input  wire logic          i_in_shift_en,
	input  wire logic [TW-1:0] i_out_shift_time,
	input  wire logic [TW-1:0] i_in_shift_time,
	input  wire logic [TW-1:0] i_sync1_period_cfg,
	input  wire logic [TW-1:0] i_sync0_period_cfg,
	input  wire logic          i_copy_period,
	input  wire logic          i_get_cycle_wr,
	input  wire logic [15:0]   i_get_cycle_data,
	input  wire logic [TW-1:0] i_min_cycle_time,
	input  wire logic [TW-1:0] i_calc_copy_time,
	input  wire logic [TW-1:0] i_delay_time,
	input  wire logic          i_clear_errors,
	output logic               o_local_cycle_start,
	output logic               o_output_update,
	output logic               o_input_latch,
	output logic [7:0]         o_out_sync_type,
	output logic [7:0]         o_in_sync_type,
	output logic [15:0]        o_out_supported,
	output logic [15:0]        o_in_supported,
	output logic [TW-1:0]      o_out_cycle_time,
	output logic [TW-1:0]      o_in_cycle_time,
	output logic [TW-1:0]      o_out_shift_time,
	output logic [TW-1:0]      o_in_shift_time,
	output logic [TW-1:0]      o_min_cycle_time,
	output logic [TW-1:0]      o_calc_copy_time,
	output logic [TW-1:0]      o_delay_time,
	output logic [TW-1:0]      o_out_sync0_time,
	output logic [TW-1:0]      o_in_sync0_time,
	output logic [15:0]        o_out_get_cycle,
	output logic [15:0]        o_in_get_cycle,
	output logic [CW-1:0]      o_out_too_small_count,
	output logic [CW-1:0]      o_in_too_small_count,
	output logic [CW-1:0]      o_out_missed_buffer_event_count,
	output logic [CW-1:0]      o_in_missed_buffer_event_count,
	output logic [CW-1:0]      o_out_shift_short_count,
	output logic [CW-1:0]      o_in_shift_short_count,
	output logic [CW-1:0]      o_out_receive_toggle_fault_count,
	output logic [CW-1:0]      o_in_receive_toggle_fault_count,
	output logic               o_out_sync_error,
	output logic               o_in_sync_error
);
	// Event pins come from another timing domain and pass two flops first.
	logic [4:0] meta_r;
	logic [4:0] sync_r;
	logic [4:0] prev_r;
	logic       sync0_rise;
	logic       sync1_rise;
	logic       buf_rise;
	logic       tog_rise;
	logic       small_rise;
	logic       tick_r;
	logic [7:0] tick_cnt_r;
	logic       buf_seen_r;
	logic       out_busy;
	logic       in_busy;
	logic [TW-1:0] cycle_r;
	logic [15:0]   get_cycle_r;
	logic [CW-1:0] too_small_r;
	logic [CW-1:0] missed_r;
	logic [CW-1:0] short_r;
	logic [CW-1:0] toggle_r;
	logic          sync_err_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_r <= 5'h00;
			sync_r <= 5'h00;
			prev_r <= 5'h00;
		end else begin
			meta_r <= {i_cycle_too_small, i_toggle_fault, i_buf_event, i_sync1, i_sync0};
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign sync0_rise = sync_r[0] & ~prev_r[0];
	assign sync1_rise = sync_r[1] & ~prev_r[1];
	assign buf_rise   = sync_r[2] & ~prev_r[2];
	assign tog_rise   = sync_r[3] & ~prev_r[3];
	assign small_rise = sync_r[4] & ~prev_r[4];

	// Local time base tick; shift times are counted in these ticks.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tick_cnt_r <= 8'h00;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == 8'(SCSS_TICK_CYCLES - 1)) begin
			tick_cnt_r <= 8'h00;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
			tick_r     <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_local_cycle_start <= 1'b0;
		end else begin
			o_local_cycle_start <= sync0_rise;
		end
	end

	// Only SYNC1 triggers the timers, and only the shift time delays them.
	scss_shift_timer #(.W(TW)) u_out_timer (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_tick   (tick_r),
		.i_trig   (sync1_rise),
		.i_enable (i_out_shift_en),
		.i_shift  (i_out_shift_time),
		.o_strobe (o_output_update),
		.o_busy   (out_busy)
	);

	scss_shift_timer #(.W(TW)) u_in_timer (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_tick   (tick_r),
		.i_trig   (sync1_rise),
		.i_enable (i_in_shift_en),
		.i_shift  (i_in_shift_time),
		.o_strobe (o_input_latch),
		.o_busy   (in_busy)
	);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cycle_r <= SCSS_CYCLE_RST;
		end else if (i_copy_period) begin
			cycle_r <= i_sync1_period_cfg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			get_cycle_r <= 16'h0000;
		end else if (i_get_cycle_wr) begin
			get_cycle_r <= i_get_cycle_data;
		end
	end

	// A buffer event arriving with SYNC1 in the same cycle counts as in time.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			buf_seen_r <= 1'b0;
		end else if (sync1_rise) begin
			buf_seen_r <= 1'b0;
		end else if (buf_rise) begin
			buf_seen_r <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			missed_r <= SCSS_COUNT_RST;
		end else if (sync1_rise && !buf_seen_r && !buf_rise) begin
			missed_r <= missed_r + 1'b1;
		end else if (i_clear_errors) begin
			missed_r <= SCSS_COUNT_RST;
		end
	end

	// A new SYNC1 while a timer still counts means the shift exceeds the period.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			short_r <= SCSS_COUNT_RST;
		end else if (sync1_rise && (out_busy || in_busy)) begin
			short_r <= short_r + 1'b1;
		end else if (i_clear_errors) begin
			short_r <= SCSS_COUNT_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			toggle_r <= SCSS_COUNT_RST;
		end else if (tog_rise) begin
			toggle_r <= toggle_r + 1'b1;
		end else if (i_clear_errors) begin
			toggle_r <= SCSS_COUNT_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			too_small_r <= SCSS_COUNT_RST;
		end else if (small_rise) begin
			too_small_r <= too_small_r + 1'b1;
		end else if (i_clear_errors) begin
			too_small_r <= SCSS_COUNT_RST;
		end
	end

	// Sticky; a new error in the clearing cycle wins.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sync_err_r <= 1'b0;
		end else if ((sync1_rise && !buf_seen_r && !buf_rise) || (sync1_rise && (out_busy || in_busy))) begin
			sync_err_r <= 1'b1;
		end else if (i_clear_errors) begin
			sync_err_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_out_shift_time <= '0;
			o_in_shift_time  <= '0;
			o_min_cycle_time <= '0;
			o_calc_copy_time <= '0;
			o_delay_time     <= '0;
			o_out_sync0_time <= '0;
		end else begin
			o_out_shift_time <= i_out_shift_time;
			o_in_shift_time  <= i_in_shift_time;
			o_min_cycle_time <= i_min_cycle_time;
			o_calc_copy_time <= i_calc_copy_time;
			o_delay_time     <= i_delay_time;
			o_out_sync0_time <= i_sync0_period_cfg;
		end
	end

	assign o_out_sync_type = SCSS_OUT_SYNC_TYPE;
	assign o_in_sync_type  = SCSS_IN_SYNC_TYPE;
	always_comb begin
		o_out_supported = 16'h0000;
		o_out_supported[SCSS_SUP_DC_LSB +: 2]    = SCSS_DC_SUBORDINATE;
		o_out_supported[SCSS_SUP_SHIFT_LSB +: 2] = i_out_shift_en ? SCSS_SHIFT_LOCAL_TIMER : SCSS_SHIFT_NONE;
		o_in_supported = 16'h0000;
		o_in_supported[SCSS_SUP_DC_LSB +: 2]     = SCSS_DC_SUBORDINATE;
		o_in_supported[SCSS_SUP_SHIFT_LSB +: 2]  = i_in_shift_en ? SCSS_SHIFT_LOCAL_TIMER : SCSS_SHIFT_NONE;
	end

	// Input-side mirrors share the output-side storage so they cannot diverge.
	assign o_out_cycle_time                 = cycle_r;
	assign o_in_cycle_time                  = cycle_r;
	assign o_in_sync0_time                  = o_out_sync0_time;
	assign o_out_get_cycle                  = get_cycle_r;
	assign o_in_get_cycle                   = get_cycle_r;
	assign o_out_too_small_count            = too_small_r;
	assign o_in_too_small_count             = too_small_r;
	assign o_out_missed_buffer_event_count  = missed_r;
	assign o_in_missed_buffer_event_count   = missed_r;
	assign o_out_shift_short_count          = short_r;
	assign o_in_shift_short_count           = short_r;
	assign o_out_receive_toggle_fault_count = toggle_r;
	assign o_in_receive_toggle_fault_count  = toggle_r;
	assign o_out_sync_error                 = sync_err_r;
	assign o_in_sync_error                  = sync_err_r;

	sync0_start_a: assert property (@(posedge i_clk) disable iff (i_srst)
		sync0_rise |=> o_local_cycle_start)
		else $error("Local cycle did not start after SYNC0.");
	no_sync0_start_a: assert property (@(posedge i_clk) disable iff (i_srst)
		!sync0_rise |=> !o_local_cycle_start)
		else $error("Local cycle started without SYNC0.");
	zero_shift_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(sync1_rise && !i_out_shift_en) |=> ##1 o_output_update)
		else $error("Unshifted output strobe missing two cycles after SYNC1.");
	strobe_cause_a: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(o_input_latch) |-> $past(in_busy, 2) || $past(sync1_rise, 2))
		else $error("Input latch strobe without SYNC1 cause.");
	out_type_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_out_sync_type == 8'h03)
		else $error("Output sync type wrong.");
	in_type_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_in_sync_type == 8'h01)
		else $error("Input sync type wrong.");
	copy_period_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_copy_period |=> o_out_cycle_time == $past(i_sync1_period_cfg))
		else $error("Cycle time not copied.");
	supported_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_out_supported[3:2] == 2'b10 && o_in_supported[3:2] == 2'b10)
		else $error("Supported field wrong.");
	missed_count_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(sync1_rise && !buf_seen_r && !buf_rise && missed_r != '1) |=> missed_r == $past(missed_r) + 1'b1)
		else $error("Missed event not counted.");
	sync_err_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(sync1_rise && !buf_seen_r && !buf_rise) |=> o_out_sync_error && o_in_sync_error)
		else $error("Sync error not raised.");
endmodule // scss_top
`default_nettype wire

// file: scss_master_model.sv
// Behavioural fieldbus master that issues the event pins seen by the sync block.
`timescale 1ns/1ns
`default_nettype none
module scss_master_model (
	output var logic [4:0] o_pin
);
	// Pins stay low between events because the master only issues them by schedule.
	initial o_pin = 5'h00;

	task automatic set_pin(input int p, input logic v);
		o_pin[p] <= v;
	endtask
endmodule // scss_master_model
`default_nettype wire

// file: scss_top_test.sv
// Self-checking testbench for the subordinate cycle sync shift block.
`timescale 1ns/1ns
`default_nettype none
module scss_top_test;
	import scss_pkg::*;
	logic        i_clk = 1'b0, i_srst = 1'b1, i_out_shift_en, i_in_shift_en;
	logic        i_copy_period, i_get_cycle_wr, i_clear_errors;
	logic [31:0] i_out_shift_time, i_in_shift_time, i_sync1_period_cfg, i_sync0_period_cfg;
	logic [31:0] i_min_cycle_time, i_calc_copy_time, i_delay_time, r;
	logic [15:0] i_get_cycle_data, miss_exp, short_exp, tog_exp, small_exp;
	logic [4:0]  pin;
	logic        o_local_cycle_start, o_output_update, o_input_latch, o_out_sync_error, o_in_sync_error, buf_seen;
	logic [7:0]  o_out_sync_type, o_in_sync_type;
	logic [15:0] o_out_supported, o_in_supported, o_out_get_cycle, o_in_get_cycle;
	logic [15:0] o_out_too_small_count, o_in_too_small_count, o_out_shift_short_count, o_in_shift_short_count;
	logic [15:0] o_out_missed_buffer_event_count, o_in_missed_buffer_event_count;
	logic [15:0] o_out_receive_toggle_fault_count, o_in_receive_toggle_fault_count;
	logic [31:0] o_out_cycle_time, o_in_cycle_time, o_out_shift_time, o_in_shift_time, o_min_cycle_time;
	logic [31:0] o_calc_copy_time, o_delay_time, o_out_sync0_time, o_in_sync0_time;
	int          fails = 0, checked = 0, cycles = 0, seed = 56, lat[3];

	always #5 i_clk = ~i_clk;

	scss_master_model mdl (.o_pin(pin));
	scss_top dut (.i_sync0(pin[0]), .i_sync1(pin[1]), .i_buf_event(pin[2]), .i_toggle_fault(pin[3]),
		.i_cycle_too_small(pin[4]), .*);

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic wrap_up;
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
	end

	function automatic int exp_lat(input logic en, input logic [31:0] n);
		return (en && n != 32'h0) ? int'(n) + 4 : 4;
	endfunction

	// Pulses one pin; with again set, SYNC1 returns while an enabled shift timer is still counting.
	task automatic fire(input int p, input bit again = 0);
		lat = '{-1, -1, -1};
		if (p == 1) begin
			miss_exp += (buf_seen ? 16'h0 : 16'h1) + (again ? 16'h1 : 16'h0);
			short_exp += again ? 16'h1 : 16'h0;
			buf_seen = 1'b0;
		end
		buf_seen |= (p == 2);
		tog_exp += (p == 3) ? 16'h1 : 16'h0;
		small_exp += (p == 4) ? 16'h1 : 16'h0;
		@(posedge i_clk);
		mdl.set_pin(p, 1'b1);
		for (int k = 1; k < 40; k++) begin
			@(posedge i_clk);
			if (k == 2 || (again && k == 10))
				mdl.set_pin(p, 1'b0);
			if (again && k == 8)
				mdl.set_pin(p, 1'b1);
			#1;
			if (o_local_cycle_start === 1'b1 && lat[0] < 0) lat[0] = k;
			if (o_output_update === 1'b1 && lat[1] < 0) lat[1] = k;
			if (o_input_latch === 1'b1 && lat[2] < 0) lat[2] = k;
		end
	endtask

	task automatic check_counts;
		cmp("out_missed", miss_exp, o_out_missed_buffer_event_count);
		cmp("in_missed", miss_exp, o_in_missed_buffer_event_count);
		cmp("out_short", short_exp, o_out_shift_short_count);
		cmp("in_short", short_exp, o_in_shift_short_count);
		cmp("out_toggle", tog_exp, o_out_receive_toggle_fault_count);
		cmp("in_toggle", tog_exp, o_in_receive_toggle_fault_count);
		cmp("out_small", small_exp, o_out_too_small_count);
		cmp("in_small", small_exp, o_in_too_small_count);
		cmp("out_err", 32'(miss_exp != 0 || short_exp != 0), 32'(o_out_sync_error));
		cmp("in_err", 32'(miss_exp != 0 || short_exp != 0), 32'(o_in_sync_error));
	endtask

	initial begin
		{i_out_shift_en, i_in_shift_en, i_copy_period, i_get_cycle_wr, i_clear_errors, buf_seen} = 6'h00;
		{i_out_shift_time, i_in_shift_time, i_sync1_period_cfg, i_sync0_period_cfg} = 128'h0;
		{i_min_cycle_time, i_calc_copy_time, i_delay_time, i_get_cycle_data} = 112'h0;
		{miss_exp, short_exp, tog_exp, small_exp} = 64'h0;
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1;
		check_counts();
		cmp("rst_cycle", 32'h0, o_out_cycle_time);
		cmp("out_type", 32'h03, o_out_sync_type);
		cmp("in_type", 32'h01, o_in_sync_type);
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clk);
			r = $random(seed);
			i_out_shift_en <= r[0];
			i_in_shift_en <= r[1];
			i_out_shift_time <= {28'h0, r[5:2]};
			i_in_shift_time <= {28'h0, r[9:6]};
			i_get_cycle_data <= r[31:16];
			i_sync1_period_cfg <= $random(seed);
			i_sync0_period_cfg <= $random(seed);
			i_min_cycle_time <= $random(seed);
			i_calc_copy_time <= $random(seed);
			i_delay_time <= $random(seed);
			i_copy_period <= 1'b1;
			i_get_cycle_wr <= 1'b1;
			@(posedge i_clk);
			i_copy_period <= 1'b0;
			i_get_cycle_wr <= 1'b0;
			@(posedge i_clk);
			#1;
			cmp("out_cycle", i_sync1_period_cfg, o_out_cycle_time);
			cmp("in_cycle", i_sync1_period_cfg, o_in_cycle_time);
			cmp("out_get", i_get_cycle_data, o_out_get_cycle);
			cmp("in_get", i_get_cycle_data, o_in_get_cycle);
			cmp("in_sync0", i_sync0_period_cfg, o_in_sync0_time);
			cmp("min_cycle", i_min_cycle_time, o_min_cycle_time);
			cmp("out_sync0", i_sync0_period_cfg, o_out_sync0_time);
			cmp("calc_copy", i_calc_copy_time, o_calc_copy_time);
			cmp("delay", i_delay_time, o_delay_time);
			cmp("out_shift", i_out_shift_time, o_out_shift_time);
			cmp("in_shift", i_in_shift_time, o_in_shift_time);
			cmp("out_sup", {26'h0, 1'b0, i_out_shift_en, 4'h8}, o_out_supported);
			cmp("in_sup", {26'h0, 1'b0, i_in_shift_en, 4'h8}, o_in_supported);
			if (r[10])
				fire(2);
			fire(1);
			cmp("sync1_loc", -1, lat[0]);
			cmp("out_lat", exp_lat(i_out_shift_en, i_out_shift_time), lat[1]);
			cmp("in_lat", exp_lat(i_in_shift_en, i_in_shift_time), lat[2]);
			fire(0);
			cmp("sync0_loc", 3, lat[0]);
			cmp("sync0_out", -1, lat[1]);
			cmp("sync0_in", -1, lat[2]);
			fire(3);
			fire(4);
			check_counts();
		end
		@(posedge i_clk);
		i_out_shift_en <= 1'b1;
		i_in_shift_en <= 1'b1;
		i_out_shift_time <= 32'h0;
		i_in_shift_time <= 32'h1;
		fire(1);
		cmp("zero_out", 4, lat[1]);
		cmp("one_in", 5, lat[2]);
		@(posedge i_clk);
		i_in_shift_en <= 1'b0;
		i_out_shift_time <= 32'h14;
		fire(1, 1);
		cmp("restart_out", 32, lat[1]);
		cmp("restart_in", 4, lat[2]);
		check_counts();
		@(posedge i_clk);
		i_out_shift_en <= 1'b0;
		i_in_shift_en <= 1'b1;
		i_in_shift_time <= 32'h14;
		fire(1, 1);
		cmp("restart_in2", 32, lat[2]);
		cmp("restart_out2", 4, lat[1]);
		check_counts();
		@(posedge i_clk);
		i_clear_errors <= 1'b1;
		@(posedge i_clk);
		i_clear_errors <= 1'b0;
		{miss_exp, short_exp, tog_exp, small_exp} = 64'h0;
		@(posedge i_clk);
		#1;
		check_counts();
		wrap_up();
	end
endmodule // scss_top_test
`default_nettype wire
